// file: parf_pin_src.sv
// partner model: external source driving the accumulator input pin
`default_nettype none
module parf_pin_src (
    input  wire logic clk,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pin = 1'b0;

    // edges kept far slower than half the clock
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (8) @(posedge clk);
            pin <= 1'b1;
            repeat (8) @(posedge clk);
            pin <= 1'b0;
        end
        repeat (8) @(posedge clk);
    endtask

    task automatic hold(input logic lvl, input int cyc);
        @(posedge clk);
        pin <= lvl;
        repeat (cyc) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: parf_pin_sync.sv
// three-stage synchroniser with agreement filter and edge pulses for the input pin
`default_nettype none
module parf_pin_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    import parf_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
        logic fall;
    } parf_sync_state_t;

    parf_sync_state_t s_r;
    parf_sync_state_t s_nxt;
    logic             agree;

    always_comb begin
        agree       = (s_r.s2 == s_r.s3);
        s_nxt.s1    = pin;
        s_nxt.s2    = s_r.s1;
        s_nxt.s3    = s_r.s2;
        s_nxt.level = agree ? s_r.s3 : s_r.level;
        s_nxt.rise  = agree & s_r.s3 & ~s_r.level;
        s_nxt.fall  = agree & ~s_r.s3 & s_r.level;
        if (!rst_n) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (ce || !rst_n) begin
            s_r <= s_nxt;
        end
    end

    assign level = s_r.level;
    assign rise  = s_r.rise;
    assign fall  = s_r.fall;

endmodule
`default_nettype wire

// file: parf_pkg.sv
// constants, bus carriers and field positions for the pulse accumulator block
`default_nettype none
package parf_pkg;

    localparam int unsigned AW = 16;
    localparam int unsigned DW = 32;

    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [AW-1:0] paddr;
        logic [DW-1:0] pwdata;
    } parf_apb_req_t;

    typedef struct packed {
        logic [DW-1:0] prdata;
        logic          pready;
        logic          pslverr;
    } parf_apb_rsp_t;

    // register indices; the byte address is four times the index
    localparam logic [AW-1:0] IDX_CTL   = 16'h1026;
    localparam logic [AW-1:0] IDX_MASK  = 16'h1030;
    localparam logic [AW-1:0] IDX_FLAGS = 16'h1031;
    localparam logic [AW-1:0] IDX_COUNT = 16'h1032;
    localparam logic [AW-1:0] IDX_FRC   = 16'h1033;

    // control register bit positions
    localparam int unsigned CTL_DIR7  = 7;
    localparam int unsigned CTL_ON    = 6;
    localparam int unsigned CTL_MODE  = 5;
    localparam int unsigned CTL_EDGE  = 4;
    localparam int unsigned CTL_DIR3  = 3;
    localparam int unsigned CTL_CCSEL = 2;
    localparam int unsigned CTL_RATE1 = 1;
    localparam int unsigned CTL_RATE0 = 0;

    // flag and mask bit positions (same layout in both)
    localparam int unsigned FLG_WRAP  = 7;
    localparam int unsigned FLG_PER   = 6;
    localparam int unsigned FLG_ACCW  = 5;
    localparam int unsigned FLG_EDGE  = 4;

    localparam logic [7:0]  FLAG_IMPL      = 8'hF0;
    localparam logic [7:0]  CTL_RESET      = 8'h00;
    localparam logic [7:0]  MASK_RESET     = 8'h00;
    localparam logic [7:0]  FLAGS_RESET    = 8'h00;
    localparam logic [15:0] FRC_ALL_ONES   = 16'hFFFF;
    localparam logic [7:0]  COUNT_ALL_ONES = 8'hFF;

    // periodic base divider exponent and gated tick divider exponent
    localparam int unsigned RTI_BASE_LOG2 = 13;
    localparam int unsigned GATE_DIV_LOG2 = 6;

endpackage
`default_nettype wire

// file: parf_rti_div.sv
// free-running periodic divider with selectable span above a fixed base
`default_nettype none
module parf_rti_div #(
    parameter int unsigned BASE_LOG2 = parf_pkg::RTI_BASE_LOG2
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic [1:0] rate_sel,
    output logic            timeout
);
    import parf_pkg::*;

    localparam int unsigned W = BASE_LOG2 + 3;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } parf_rti_state_t;

    parf_rti_state_t s_r;
    parf_rti_state_t s_nxt;
    logic [W-1:0]    span;

    // only reset clears the chain, so periods run from timeout to timeout
    always_comb begin
        span       = {W{1'b1}} >> (2'd3 - rate_sel);
        s_nxt.cnt  = s_r.cnt + 1'b1;
        s_nxt.tick = ((s_r.cnt & span) == span);
        if (!rst_n) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (ce || !rst_n) begin
            s_r <= s_nxt;
        end
    end

    assign timeout = s_r.tick;

endmodule
`default_nettype wire

// file: parf_top.sv
// pulse accumulator, periodic interrupt timer and second timer flag register
//
// Register access over APB was left to the implementer.
`default_nettype none
module parf_top #(
    parameter int unsigned RTI_LOG2 = parf_pkg::RTI_BASE_LOG2
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    input  wire parf_pkg::parf_apb_req_t apb_req,
    output parf_pkg::parf_apb_rsp_t      apb_rsp,
    input  wire logic                    accumulator_input_pin,
    output logic                         irq_request,
    output logic                         porta_dir_bit7,
    output logic                         porta_dir_bit3,
    output logic                         capture_compare_select
);
    import parf_pkg::*;

    typedef struct packed {
        logic [7:0]               ctl;
        logic [7:0]               mask;
        logic [7:0]               flags;
        logic [7:0]               accumulator_count;
        logic [15:0]              frc;
        logic [GATE_DIV_LOG2-1:0] gdiv;
        logic                     gtick;
        parf_apb_rsp_t            rsp;
        logic                     irq;
    } parf_top_state_t;

    parf_top_state_t s_r;
    parf_top_state_t s_nxt;

    logic        pin_level;
    logic        pin_rise;
    logic        pin_fall;
    logic        rti_tick;
    logic        take;
    logic        wr_now;
    logic        wr_ctl;
    logic        wr_mask;
    logic        wr_flags;
    logic        wr_count;
    logic        mapped;
    logic        acc_on;
    logic        acc_mode;
    logic        edge_sel;
    logic        sel_edge;
    logic        gate_open;
    logic        inc;
    logic        acc_wrap;
    logic        frc_wrap;
    logic [7:0]  clr;
    logic [15:0] rd_val;

    function automatic logic hit(input logic [AW-1:0] addr, input logic [AW-1:0] idx);
        return addr == {idx[AW-3:0], 2'b00};
    endfunction

    // a hardware set in the same cycle as a clear wins
    function automatic logic flag_upd(input logic cur, input logic set, input logic clear);
        return set | (cur & ~clear);
    endfunction

    parf_pin_sync u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .pin   (accumulator_input_pin),
        .level (pin_level),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    parf_rti_div #(
        .BASE_LOG2 (RTI_LOG2)
    ) u_rti (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .rate_sel ({s_r.ctl[CTL_RATE1], s_r.ctl[CTL_RATE0]}),
        .timeout  (rti_tick)
    );

    always_comb begin
        s_nxt = s_r;

        // bus decode: data captured while waiting, write lands on the ready edge
        take     = apb_req.psel & ~s_r.rsp.pready;
        wr_now   = apb_req.psel & apb_req.penable & apb_req.pwrite & s_r.rsp.pready;
        wr_ctl   = wr_now & hit(apb_req.paddr, IDX_CTL);
        wr_mask  = wr_now & hit(apb_req.paddr, IDX_MASK);
        wr_flags = wr_now & hit(apb_req.paddr, IDX_FLAGS);
        wr_count = wr_now & hit(apb_req.paddr, IDX_COUNT);
        mapped   = hit(apb_req.paddr, IDX_CTL) | hit(apb_req.paddr, IDX_MASK)
                 | hit(apb_req.paddr, IDX_FLAGS) | hit(apb_req.paddr, IDX_COUNT)
                 | hit(apb_req.paddr, IDX_FRC);

        // unimplemented flag and mask bits read zero
        rd_val = 16'h0000;
        if (hit(apb_req.paddr, IDX_CTL)) begin
            rd_val = {8'h00, s_r.ctl};
        end else if (hit(apb_req.paddr, IDX_MASK)) begin
            rd_val = {8'h00, s_r.mask};
        end else if (hit(apb_req.paddr, IDX_FLAGS)) begin
            rd_val = {8'h00, s_r.flags & FLAG_IMPL};
        end else if (hit(apb_req.paddr, IDX_COUNT)) begin
            rd_val = {8'h00, s_r.accumulator_count};
        end else if (hit(apb_req.paddr, IDX_FRC)) begin
            rd_val = s_r.frc;
        end

        s_nxt.rsp.pready  = take;
        s_nxt.rsp.pslverr = take & ~mapped;
        s_nxt.rsp.prdata  = (take & ~apb_req.pwrite) ? {16'h0000, rd_val} : '0;

        if (wr_ctl) begin
            s_nxt.ctl = apb_req.pwdata[7:0];
        end
        if (wr_mask) begin
            s_nxt.mask = apb_req.pwdata[7:0] & FLAG_IMPL;
        end

        s_nxt.frc = s_r.frc + 16'h0001;
        frc_wrap  = (s_r.frc == FRC_ALL_ONES);

        // gated tick runs free whatever the enable
        s_nxt.gdiv  = s_r.gdiv + 1'b1;
        s_nxt.gtick = (s_r.gdiv == {GATE_DIV_LOG2{1'b1}});

        acc_on   = s_r.ctl[CTL_ON];
        acc_mode = s_r.ctl[CTL_MODE];
        edge_sel = s_r.ctl[CTL_EDGE];
        sel_edge = edge_sel ? pin_rise : pin_fall;
        gate_open = pin_level ^ edge_sel;
        inc = acc_on & (acc_mode ? (s_r.gtick & gate_open) : sel_edge);

        // software load beats a same-cycle increment; reads use the settled value
        acc_wrap = 1'b0;
        if (wr_count) begin
            s_nxt.accumulator_count = apb_req.pwdata[7:0];
        end else if (inc) begin
            s_nxt.accumulator_count = s_r.accumulator_count + 8'h01;
            acc_wrap    = (s_r.accumulator_count == COUNT_ALL_ONES);
        end

        clr = wr_flags ? (apb_req.pwdata[7:0] & FLAG_IMPL) : 8'h00;
        s_nxt.flags[FLG_WRAP] = flag_upd(s_r.flags[FLG_WRAP], frc_wrap, clr[FLG_WRAP]);
        s_nxt.flags[FLG_PER]  = flag_upd(s_r.flags[FLG_PER], rti_tick, clr[FLG_PER]);
        s_nxt.flags[FLG_ACCW] = flag_upd(s_r.flags[FLG_ACCW], acc_wrap, clr[FLG_ACCW]);
        s_nxt.flags[FLG_EDGE] = flag_upd(s_r.flags[FLG_EDGE], acc_on & sel_edge,
                                         clr[FLG_EDGE]);
        s_nxt.flags[3:0] = 4'h0;

        s_nxt.irq = |(s_r.flags & s_r.mask & FLAG_IMPL);

        if (!rst_n) begin
            s_nxt         = '0;
            s_nxt.ctl     = CTL_RESET;
            s_nxt.mask    = MASK_RESET;
            s_nxt.flags   = FLAGS_RESET;
            s_nxt.accumulator_count   = s_r.accumulator_count;
        end
    end

    always_ff @(posedge clk) begin
        if (ce || !rst_n) begin
            s_r <= s_nxt;
        end
    end

    assign apb_rsp                = s_r.rsp;
    assign irq_request            = s_r.irq;
    assign porta_dir_bit7         = s_r.ctl[CTL_DIR7];
    assign porta_dir_bit3         = s_r.ctl[CTL_DIR3];
    assign capture_compare_select = s_r.ctl[CTL_CCSEL];

    a_wrap_sets_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_r.frc == FRC_ALL_ONES) |=> s_r.flags[FLG_WRAP]
    ) else $error("counter wrap did not set the wrap flag");

    a_zero_write_keeps: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_flags && !apb_req.pwdata[FLG_PER] && s_r.flags[FLG_PER])
        |=> s_r.flags[FLG_PER]
    ) else $error("flag lost on a zero write");

    a_period_flag_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && rti_tick) |=> s_r.flags[FLG_PER]
    ) else $error("period end did not set the periodic flag");

    a_low_bits_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && take && !apb_req.pwrite && hit(apb_req.paddr, IDX_FLAGS))
        |=> (s_r.rsp.prdata[3:0] == 4'h0)
    ) else $error("unimplemented flag bits read non-zero");

    a_irq_follows: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_r.flags[FLG_PER] && s_r.mask[FLG_PER] && !wr_flags && !wr_mask)
        |=> ##1 (irq_request || !ce)
    ) else $error("periodic flag with enable raised no request");

    a_disabled_holds: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && !s_r.ctl[CTL_ON] && !wr_count) |=> $stable(s_r.accumulator_count)
    ) else $error("disabled accumulator changed its count");

    a_event_counts: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && acc_on && !acc_mode && sel_edge && !wr_count)
        |=> s_r.accumulator_count == 8'($past(s_r.accumulator_count) + 8'h01)
    ) else $error("selected edge did not advance the count");

    a_gate_inhibits: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && acc_on && acc_mode && !gate_open && !wr_count) |=> $stable(s_r.accumulator_count)
    ) else $error("inhibited gate still counted");

    a_acc_wrap_flag: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && inc && !wr_count && s_r.accumulator_count == COUNT_ALL_ONES)
        |=> (s_r.flags[FLG_ACCW] && s_r.accumulator_count == 8'h00)
    ) else $error("count rollover did not set its flag");

    a_set_beats_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && acc_on && sel_edge && wr_flags && apb_req.pwdata[FLG_EDGE])
        |=> s_r.flags[FLG_EDGE]
    ) else $error("edge event lost against a clear");

    a_period_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_flags && apb_req.pwdata[FLG_PER] && !rti_tick) |=> !s_r.flags[FLG_PER]
    ) else $error("periodic flag survived its clear");

    a_wrap_irq: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_r.flags[FLG_WRAP] && s_r.mask[FLG_WRAP]) |=> irq_request
    ) else $error("wrap flag with enable raised no request");

    a_irq_needs_enable: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && (s_r.flags & s_r.mask) == 8'h00) |=> !irq_request
    ) else $error("request raised with no enabled flag");

    a_edge_flag_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && acc_on && sel_edge) |=> s_r.flags[FLG_EDGE]
    ) else $error("selected edge did not set the edge flag");

    a_edge_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_flags && apb_req.pwdata[FLG_EDGE] && !(acc_on && sel_edge))
        |=> !s_r.flags[FLG_EDGE]
    ) else $error("edge flag survived a one write");

    a_acc_wrap_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_flags && apb_req.pwdata[FLG_ACCW] && !acc_wrap)
        |=> !s_r.flags[FLG_ACCW]
    ) else $error("accumulator wrap flag survived a one write");

    a_gated_counts: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && acc_on && acc_mode && s_r.gtick && gate_open && !wr_count)
        |=> s_r.accumulator_count == 8'($past(s_r.accumulator_count) + 8'h01)
    ) else $error("open gate missed a tick");

    a_gated_no_tick: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && acc_on && acc_mode && !s_r.gtick && !wr_count) |=> $stable(s_r.accumulator_count)
    ) else $error("gated count moved between ticks");

    a_tick_single: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && s_r.gtick) |=> !s_r.gtick
    ) else $error("gated tick lasted more than one cycle");

    a_count_load: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_count) |=> s_r.accumulator_count == $past(apb_req.pwdata[7:0])
    ) else $error("count write did not load");

    a_ctl_reset: assert property (
        @(posedge clk)
        !rst_n |=> (s_r.ctl == CTL_RESET && s_r.flags == FLAGS_RESET && !irq_request
                    && !porta_dir_bit7 && !porta_dir_bit3 && !capture_compare_select)
    ) else $error("reset left control state set");

    a_port_dirs: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_ctl) |=> (porta_dir_bit7 == $past(apb_req.pwdata[CTL_DIR7])
                            && porta_dir_bit3 == $past(apb_req.pwdata[CTL_DIR3]))
    ) else $error("direction bits did not follow the control write");

    a_ccsel_follows: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_ctl) |=> capture_compare_select == $past(apb_req.pwdata[CTL_CCSEL])
    ) else $error("select bit did not follow the control write");

    a_event_only_edges: assert property (
        @(posedge clk) disable iff (!rst_n)
        (ce && acc_on && !acc_mode && !sel_edge && !wr_count)
        |=> $stable(s_r.accumulator_count)
    ) else $error("event mode counted without an edge");

endmodule
`default_nettype wire

// file: tb_top.sv
// self-checking testbench for the pulse accumulator and periodic timer block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import parf_pkg::*;

    // short periodic base keeps the run small
    localparam int unsigned RLOG = 4;

    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          ce = 1'b1;
    parf_apb_req_t req = '0;
    parf_apb_rsp_t rsp;
    logic          pin, irq, dir7, dir3, ccsel, re;
    logic [31:0]   rv;
    int            fails = 0, check_count = 0, cyc = 0, t_rel = 0;

    parf_top #(.RTI_LOG2(RLOG)) dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .apb_req(req), .apb_rsp(rsp),
        .accumulator_input_pin(pin), .irq_request(irq), .porta_dir_bit7(dir7),
        .porta_dir_bit3(dir3), .capture_compare_select(ccsel));
    parf_pin_src src (.clk(clk), .pin(pin));

    initial forever #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input logic [7:0] got);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fails++;
            $display("Error %s expected %0d..%0d seen %h", nm, lo, hi, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        int n;
        @(posedge clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= idx << 2;
        req.pwdata <= {24'h0, wd};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 64);
        if (n >= 64) begin
            fails++;
            $display("Error apb pready expected 1 seen 0");
        end
        rv = rsp.prdata;
        re = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rd(input logic [15:0] idx);
        apb(1'b0, idx, 8'h00);
    endtask

    task automatic chk_irq(input logic exp);
        repeat (4) @(posedge clk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_rel = cyc;
    endtask

    task automatic t_reset;
        rd(IDX_CTL);
        chk("ctl", 32'h0, rv);
        rd(IDX_MASK);
        chk("mask", 32'h0, rv);
        rd(IDX_FLAGS);
        chk("flags", 32'h0, rv);
        chk("outs", 32'h0, {dir7, dir3, ccsel});
    endtask

    task automatic t_ctl;
        wr(IDX_CTL, 8'h8C);
        rd(IDX_CTL);
        chk("ctl", 32'h8C, rv);
        chk("outs", 32'h7, {dir7, dir3, ccsel});
        rd(16'h1040);
        chk("slverr", 32'h1, re);
        chk("rdata", 32'h0, rv);
    endtask

    task automatic t_event(input logic e);
        wr(IDX_CTL, {3'b010, e, 4'h0});
        wr(IDX_COUNT, 8'hFE);
        wr(IDX_FLAGS, 8'h30);
        src.pulses(2);
        src.hold(1'b1, 16);
        rd(IDX_COUNT);
        chk("count", e ? 32'h1 : 32'h0, rv);
        rd(IDX_FLAGS);
        chk("flags", 32'h30, rv & 32'h3F);
        wr(IDX_MASK, 8'h20);
        chk_irq(1'b1);
        wr(IDX_FLAGS, 8'h00);
        wr(IDX_FLAGS, 8'h10);
        rd(IDX_FLAGS);
        chk("flags", 32'h20, rv & 32'h3F);
        wr(IDX_MASK, 8'h10);
        chk_irq(1'b0);
        src.hold(1'b0, 16);
        chk_irq(!e);
        wr(IDX_FLAGS, 8'h30);
        wr(IDX_MASK, 8'h00);
    endtask

    task automatic t_off;
        wr(IDX_CTL, 8'h00);
        wr(IDX_COUNT, 8'h33);
        src.pulses(2);
        rd(IDX_COUNT);
        chk("count", 32'h33, rv);
        rd(IDX_FLAGS);
        chk("flags", 32'h0, rv & 32'h30);
    endtask

    task automatic t_gated;
        logic [7:0] v;
        wr(IDX_CTL, 8'h60);
        wr(IDX_COUNT, 8'h00);
        rd(IDX_COUNT);
        chk("count", 32'h0, rv);
        src.hold(1'b1, 640);
        src.hold(1'b0, 8);
        rd(IDX_COUNT);
        chk_rng("count", 9, 11, rv[7:0]);
        v = rv[7:0];
        src.hold(1'b0, 640);
        rd(IDX_COUNT);
        chk("count", {24'h0, v}, rv);
        wr(IDX_CTL, 8'h70);
        src.hold(1'b0, 640);
        src.hold(1'b1, 8);
        rd(IDX_COUNT);
        chk_rng("count", v + 9, v + 12, rv[7:0]);
        src.hold(1'b0, 8);
    endtask

    // flag clear lags the timeout on purpose: spacing must not move
    task automatic next_tick(output int t);
        int n;
        wr(IDX_FLAGS, 8'h40);
        n = 0;
        while (irq !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        while (irq !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        if (n >= 600) begin
            fails++;
            $display("Error tick expected irq 1 seen 0");
        end
        t = cyc;
    endtask

    task automatic t_periodic(input logic [1:0] r);
        int t1, t2;
        wr(IDX_CTL, {6'h00, r});
        wr(IDX_MASK, 8'h40);
        next_tick(t1);
        next_tick(t1);
        next_tick(t2);
        chk("period", 1 << (RLOG + r), t2 - t1);
        wr(IDX_MASK, 8'h00);
    endtask

    // clock enable low must freeze the free counter
    task automatic t_freeze;
        logic [31:0] a;
        rd(IDX_FRC);
        a = rv;
        @(posedge clk);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        rd(IDX_FRC);
        chk("frc", a + 32'd4, rv);
    endtask

    task automatic t_wrap;
        wr(IDX_COUNT, 8'h5A);
        do_reset;
        rd(IDX_COUNT);
        chk("count", 32'h5A, rv);
        while (cyc - t_rel < 65500) @(posedge clk);
        rd(IDX_FLAGS);
        chk("flags", 32'h0, rv & 32'h80);
        wr(IDX_MASK, 8'h80);
        while (cyc - t_rel < 65600) @(posedge clk);
        rd(IDX_FLAGS);
        chk("flags", 32'h80, rv & 32'h80);
        chk("irq", 32'h1, {31'h0, irq});
        wr(IDX_FLAGS, 8'h80);
        chk_irq(1'b0);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        wrap_up();
    end

    initial begin
        do_reset;
        t_reset;
        t_ctl;
        for (int e = 0; e < 2; e++) t_event(e[0]);
        t_off;
        t_gated;
        for (int r = 0; r < 4; r++) t_periodic(r[1:0]);
        t_freeze;
        t_wrap;
        wrap_up();
    end
endmodule
`default_nettype wire
